// *** rtl/reco_clk_pkg.sv ***
// constants for the recovered clock output selector
package reco_clk_pkg;
  localparam int unsigned NUM_GIG_LANES = 8;
  localparam int unsigned NUM_FAST_LANES = 2;
  localparam int unsigned NUM_PINS = 10;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;

  // register byte offsets
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_SELECT = 8'h04;
  localparam logic [7:0] OFS_COMMON_DIV = 8'h08;
  localparam logic [7:0] OFS_GIG_CLK_SEL = 8'h0c;
  localparam logic [7:0] OFS_FAST_CLK_SEL = 8'h10;
  localparam logic [7:0] OFS_GIG_DIV = 8'h14;
  localparam logic [7:0] OFS_FAST_DIV = 8'h18;
  localparam logic [7:0] OFS_SQUELCH = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;

  // field positions
  localparam int unsigned PIN0_SEL_LSB = 16;
  localparam int unsigned PIN0_SEL_W = 4;
  localparam int unsigned AUTO_SQ_LSB = 16;
  localparam int unsigned STICKY_LSB = 16;
  localparam int unsigned DIV_W = 2;

  // divider encodings
  localparam logic [1:0] DIV_BY_1 = 2'h0;
  localparam logic [1:0] DIV_BY_4 = 2'h1;
  localparam logic [1:0] DIV_BY_5 = 2'h2;
  localparam logic [3:0] DIV4_PERIOD = 4'h4;
  localparam logic [3:0] DIV4_HIGH = 4'h2;
  localparam logic [3:0] DIV5_PERIOD = 4'h5;
  localparam logic [3:0] DIV5_HIGH = 4'h3;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // register indices
  typedef enum logic [3:0] {
    REG_ENABLE = 4'h0,
    REG_SELECT = 4'h1,
    REG_COMMON_DIV = 4'h2,
    REG_GIG_CLK_SEL = 4'h3,
    REG_FAST_CLK_SEL = 4'h4,
    REG_GIG_DIV = 4'h5,
    REG_FAST_DIV = 4'h6,
    REG_SQUELCH = 4'h7,
    REG_STATUS = 4'h8,
    REG_NONE = 4'hf
  } reg_idx_t;
endpackage

// *** rtl/reco_clk_divider.sv ***
// divides a sampled recovered clock level by 1, 4 or 5
`timescale 1ns/1ps
module reco_clk_divider (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic src_level,
  input wire logic [1:0] div_sel,
  output logic div_level
);
  logic src_prev_r;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [3:0] period;
  logic [3:0] high_len;
  logic div_level_r;
  logic rise;

  assign rise = src_level & ~src_prev_r;
  assign div_level = div_level_r;

  always_comb begin
    period = reco_clk_pkg::DIV4_PERIOD;
    high_len = reco_clk_pkg::DIV4_HIGH;
    if (div_sel == reco_clk_pkg::DIV_BY_5) begin
      period = reco_clk_pkg::DIV5_PERIOD;
      high_len = reco_clk_pkg::DIV5_HIGH;
    end
    cnt_nxt = cnt_r;
    if (rise) begin
      cnt_nxt = (cnt_r >= period - 4'h1) ? 4'h0 : cnt_r + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      src_prev_r <= 1'b0;
    end else begin
      src_prev_r <= src_level;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 4'h0;
      div_level_r <= 1'b0;
    end else if (div_sel == reco_clk_pkg::DIV_BY_4 ||
                 div_sel == reco_clk_pkg::DIV_BY_5) begin
      cnt_r <= cnt_nxt;
      div_level_r <= (cnt_nxt < high_len);
    end else begin
      // undivided or reserved code: pass the clock straight on
      cnt_r <= 4'h0;
      div_level_r <= src_level;
    end
  end
endmodule // reco_clk_divider

// *** rtl/recovered_clock_output_select.sv ***
// recovered clock routing, division and squelch with axi4-lite registers
//
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module recovered_clock_output_select #(
  parameter int unsigned NUM_GIG = reco_clk_pkg::NUM_GIG_LANES,
  parameter int unsigned NUM_FAST = reco_clk_pkg::NUM_FAST_LANES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [NUM_GIG-1:0] gig_lane_clk,
  input wire logic [NUM_FAST-1:0] fast_lane_clk,
  input wire logic [NUM_GIG+NUM_FAST-1:0] lane_timing_bad,
  output logic [NUM_GIG+NUM_FAST-1:0] recovered_clock_out_pin,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int unsigned NP = NUM_GIG + NUM_FAST;

  generate
    if (NUM_GIG != reco_clk_pkg::NUM_GIG_LANES ||
        NUM_FAST != reco_clk_pkg::NUM_FAST_LANES) begin : g_bad_cfg
      $error("lane counts must match the register layout");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // decode shared by the read and write paths
  function automatic reco_clk_pkg::reg_idx_t decode(input logic [7:0] a);
    case (a)
      reco_clk_pkg::OFS_ENABLE: decode = reco_clk_pkg::REG_ENABLE;
      reco_clk_pkg::OFS_SELECT: decode = reco_clk_pkg::REG_SELECT;
      reco_clk_pkg::OFS_COMMON_DIV: decode = reco_clk_pkg::REG_COMMON_DIV;
      reco_clk_pkg::OFS_GIG_CLK_SEL: decode = reco_clk_pkg::REG_GIG_CLK_SEL;
      reco_clk_pkg::OFS_FAST_CLK_SEL: decode = reco_clk_pkg::REG_FAST_CLK_SEL;
      reco_clk_pkg::OFS_GIG_DIV: decode = reco_clk_pkg::REG_GIG_DIV;
      reco_clk_pkg::OFS_FAST_DIV: decode = reco_clk_pkg::REG_FAST_DIV;
      reco_clk_pkg::OFS_SQUELCH: decode = reco_clk_pkg::REG_SQUELCH;
      reco_clk_pkg::OFS_STATUS: decode = reco_clk_pkg::REG_STATUS;
      default: decode = reco_clk_pkg::REG_NONE;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // bus slave
  logic [31:0] enable_reg_r;
  logic [31:0] select_reg_r;
  logic [31:0] common_div_reg_r;
  logic [31:0] gig_clk_sel_reg_r;
  logic [31:0] fast_clk_sel_reg_r;
  logic [31:0] gig_div_reg_r;
  logic [31:0] fast_div_reg_r;
  logic [31:0] squelch_reg_r;
  logic [NP-1:0] bad_sticky_r;
  logic [NP-1:0] squelch_now;
  logic [NP-1:0] pin_live;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic wr_fire;
  logic rd_fire;
  reco_clk_pkg::reg_idx_t wr_idx;
  reco_clk_pkg::reg_idx_t rd_idx;
  logic [31:0] status_word;

  // both halves are taken together so neither can outrun the other
  assign wr_fire = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign rd_fire = s_axi_arvalid & ~rvalid_r;
  assign s_axi_arready = rd_fire;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign wr_idx = decode(s_axi_awaddr);
  assign rd_idx = decode(s_axi_araddr);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bvalid_r <= 1'b0;
      bresp_r <= reco_clk_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= (wr_idx == reco_clk_pkg::REG_NONE) ?
                 reco_clk_pkg::RESP_SLVERR : reco_clk_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rvalid_r <= 1'b0;
      rresp_r <= reco_clk_pkg::RESP_OKAY;
      rdata_r <= reco_clk_pkg::RST_ZERO;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rresp_r <= reco_clk_pkg::RESP_OKAY;
      case (rd_idx)
        reco_clk_pkg::REG_ENABLE: rdata_r <= enable_reg_r;
        reco_clk_pkg::REG_SELECT: rdata_r <= select_reg_r;
        reco_clk_pkg::REG_COMMON_DIV: rdata_r <= common_div_reg_r;
        reco_clk_pkg::REG_GIG_CLK_SEL: rdata_r <= gig_clk_sel_reg_r;
        reco_clk_pkg::REG_FAST_CLK_SEL: rdata_r <= fast_clk_sel_reg_r;
        reco_clk_pkg::REG_GIG_DIV: rdata_r <= gig_div_reg_r;
        reco_clk_pkg::REG_FAST_DIV: rdata_r <= fast_div_reg_r;
        reco_clk_pkg::REG_SQUELCH: rdata_r <= squelch_reg_r;
        reco_clk_pkg::REG_STATUS: rdata_r <= status_word;
        default: begin
          rdata_r <= reco_clk_pkg::RST_ZERO;
          rresp_r <= reco_clk_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // writable registers keep only their defined bits; the rest read zero
  localparam logic [31:0] MASK_PINS = 32'h0000_03ff;
  localparam logic [31:0] MASK_SELECT = 32'h000f_03ff;
  localparam logic [31:0] MASK_DIV1 = 32'h0000_0003;
  localparam logic [31:0] MASK_GIG = 32'h0000_00ff;
  localparam logic [31:0] MASK_FAST = 32'h0000_0003;
  localparam logic [31:0] MASK_GIG_DIV = 32'h0000_ffff;
  localparam logic [31:0] MASK_FAST_DIV = 32'h0000_000f;
  localparam logic [31:0] MASK_SQUELCH = 32'h03ff_03ff;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      enable_reg_r <= reco_clk_pkg::RST_ZERO;
      select_reg_r <= reco_clk_pkg::RST_ZERO;
      common_div_reg_r <= reco_clk_pkg::RST_ZERO;
      gig_clk_sel_reg_r <= reco_clk_pkg::RST_ZERO;
      fast_clk_sel_reg_r <= reco_clk_pkg::RST_ZERO;
      gig_div_reg_r <= reco_clk_pkg::RST_ZERO;
      fast_div_reg_r <= reco_clk_pkg::RST_ZERO;
      squelch_reg_r <= reco_clk_pkg::RST_ZERO;
    end else if (wr_fire) begin
      case (wr_idx)
        reco_clk_pkg::REG_ENABLE: enable_reg_r <= MASK_PINS &
          merge(enable_reg_r, s_axi_wdata, s_axi_wstrb);
        reco_clk_pkg::REG_SELECT: select_reg_r <= MASK_SELECT &
          merge(select_reg_r, s_axi_wdata, s_axi_wstrb);
        reco_clk_pkg::REG_COMMON_DIV: common_div_reg_r <= MASK_DIV1 &
          merge(common_div_reg_r, s_axi_wdata, s_axi_wstrb);
        reco_clk_pkg::REG_GIG_CLK_SEL: gig_clk_sel_reg_r <= MASK_GIG &
          merge(gig_clk_sel_reg_r, s_axi_wdata, s_axi_wstrb);
        reco_clk_pkg::REG_FAST_CLK_SEL: fast_clk_sel_reg_r <= MASK_FAST &
          merge(fast_clk_sel_reg_r, s_axi_wdata, s_axi_wstrb);
        reco_clk_pkg::REG_GIG_DIV: gig_div_reg_r <= MASK_GIG_DIV &
          merge(gig_div_reg_r, s_axi_wdata, s_axi_wstrb);
        reco_clk_pkg::REG_FAST_DIV: fast_div_reg_r <= MASK_FAST_DIV &
          merge(fast_div_reg_r, s_axi_wdata, s_axi_wstrb);
        reco_clk_pkg::REG_SQUELCH: squelch_reg_r <= MASK_SQUELCH &
          merge(squelch_reg_r, s_axi_wdata, s_axi_wstrb);
        default: ;
      endcase
    end
  end

  // sticky record of bad timing; a new event beats a same-cycle clear
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bad_sticky_r <= '0;
    end else begin
      for (int i = 0; i < NP; i++) begin
        if (lane_timing_bad[i]) begin
          bad_sticky_r[i] <= 1'b1;
        end else if (wr_fire && wr_idx == reco_clk_pkg::REG_STATUS &&
                     s_axi_wstrb[(reco_clk_pkg::STICKY_LSB + i) / 8] &&
                     s_axi_wdata[reco_clk_pkg::STICKY_LSB + i]) begin
          bad_sticky_r[i] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    status_word = reco_clk_pkg::RST_ZERO;
    status_word[NP-1:0] = pin_live;
    status_word[reco_clk_pkg::STICKY_LSB +: NP] = bad_sticky_r;
  end

  //////////////////////////////////////////////////////////////////////////
  // lanes, buses and dividers
  logic [NP-1:0] lane_clk;
  logic [NP-1:0] lane_drives_common;
  logic [NP*reco_clk_pkg::DIV_W-1:0] lane_div;
  logic [NP-1:0] indiv_bus;
  logic common_src;
  logic common_bus;

  assign lane_clk = {fast_lane_clk, gig_lane_clk};
  assign lane_drives_common = {fast_clk_sel_reg_r[NUM_FAST-1:0],
                               gig_clk_sel_reg_r[NUM_GIG-1:0]};
  assign lane_div = {fast_div_reg_r[NUM_FAST*reco_clk_pkg::DIV_W-1:0],
                     gig_div_reg_r[NUM_GIG*reco_clk_pkg::DIV_W-1:0]};

  // lowest enabled lane owns the shared bus, so two drivers never fight
  always_comb begin
    common_src = 1'b0;
    for (int i = NP - 1; i >= 0; i--) begin
      if (lane_drives_common[i]) begin
        common_src = lane_clk[i];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_lane
      reco_clk_divider u_div (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .src_level(lane_clk[g]),
        .div_sel(lane_div[g*reco_clk_pkg::DIV_W +: reco_clk_pkg::DIV_W]),
        .div_level(indiv_bus[g])
      );
    end
  endgenerate

  reco_clk_divider u_common_div (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .src_level(common_src),
    .div_sel(common_div_reg_r[reco_clk_pkg::DIV_W-1:0]),
    .div_level(common_bus)
  );

  //////////////////////////////////////////////////////////////////////////
  // pin selection, squelch and gating
  logic [NP-1:0] pin_choice;
  logic [reco_clk_pkg::PIN0_SEL_W-1:0] pin0_sel;
  logic pin0_clk;
  logic [NP-1:0] pin_out_r;

  assign pin0_sel = select_reg_r[reco_clk_pkg::PIN0_SEL_LSB +:
                                 reco_clk_pkg::PIN0_SEL_W];

  always_comb begin
    for (int i = 0; i < NP; i++) begin
      pin_choice[i] = select_reg_r[i] ? common_bus : indiv_bus[i];
    end
  end

  // code zero or an out-of-range code keeps pin 0 on its own choice
  always_comb begin
    pin0_clk = pin_choice[0];
    for (int k = 1; k < NP; k++) begin
      if (pin0_sel == k[reco_clk_pkg::PIN0_SEL_W-1:0]) begin
        pin0_clk = pin_choice[k];
      end
    end
  end

  assign squelch_now = squelch_reg_r[NP-1:0] |
    (lane_timing_bad & squelch_reg_r[reco_clk_pkg::AUTO_SQ_LSB +: NP]);
  assign pin_live = enable_reg_r[NP-1:0] & ~squelch_now;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pin_out_r <= '0;
    end else begin
      for (int i = 0; i < NP; i++) begin
        if (!pin_live[i]) begin
          pin_out_r[i] <= 1'b0;
        end else if (i == 0) begin
          pin_out_r[i] <= pin0_clk;
        end else begin
          pin_out_r[i] <= pin_choice[i];
        end
      end
    end
  end

  assign recovered_clock_out_pin = pin_out_r;
endmodule // recovered_clock_output_select

// *** test/reco_clk_properties.sv ***
// concurrent checks on the recovered clock selector ports
`timescale 1ns/1ps
module reco_clk_properties #(
  parameter int unsigned NUM_GIG = 8,
  parameter int unsigned NUM_FAST = 2
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [NUM_GIG+NUM_FAST-1:0] recovered_clock_out_pin,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic aw_hs, ar_hs;
  logic [9:0] en_r, en_d;
  assign aw_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                 s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  //////////////////////////////////////////////////////////////////////////
  // enable shadow; en_d lags because the pin flop sits after the register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      en_r <= 10'h000;
      en_d <= 10'h000;
    end else begin
      en_d <= en_r;
      if (aw_hs && s_axi_awaddr == reco_clk_pkg::OFS_ENABLE) begin
        if (s_axi_wstrb[0]) en_r[7:0] <= s_axi_wdata[7:0];
        if (s_axi_wstrb[1]) en_r[9:8] <= s_axi_wdata[9:8];
      end
    end
  end
  AST_DISABLED_PIN_LOW: assert property (
    (recovered_clock_out_pin[9:0] & ~en_d) == 10'h000)
    else $error("pin active while disabled");
  AST_PINS_LOW_AFTER_RESET: assert property (
    $rose(nrst) |-> recovered_clock_out_pin == '0)
    else $error("pins not low after reset");
  AST_WRITE_ANSWER: assert property (aw_hs |=> s_axi_bvalid)
    else $error("write response late");
  AST_READ_ANSWER: assert property (ar_hs |=> s_axi_rvalid)
    else $error("read response late");
  AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read response dropped");
  AST_NO_WRITE_WHILE_BVALID: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_NO_READ_WHILE_RVALID: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while response pending");
  AST_UNMAPPED_READ: assert property (
    ar_hs && s_axi_araddr > reco_clk_pkg::OFS_STATUS |=>
    s_axi_rresp == reco_clk_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_UNMAPPED_WRITE: assert property (
    aw_hs && s_axi_awaddr > reco_clk_pkg::OFS_STATUS |=>
    s_axi_bresp == reco_clk_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");
  cover property (aw_hs && s_axi_awaddr == reco_clk_pkg::OFS_SQUELCH);
  cover property (ar_hs && s_axi_araddr > reco_clk_pkg::OFS_STATUS);
  cover property ($rose(recovered_clock_out_pin[0]));
endmodule // reco_clk_properties

bind recovered_clock_output_select reco_clk_properties #(
  .NUM_GIG(NUM_GIG), .NUM_FAST(NUM_FAST)
) u_props (
  .sys_clk(sys_clk), .nrst(nrst),
  .recovered_clock_out_pin(recovered_clock_out_pin),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready)
);

// *** test/reco_pin_sink.sv ***
// edge counting model of the external timing circuitry
`timescale 1ns/1ps
module reco_pin_sink (
  input wire logic sys_clk,
  input wire logic clear,
  input wire logic [9:0] pins,
  output logic [9:0][7:0] edge_cnt
);
  logic [9:0] prev_r;
  // one counter per pin; a held pin gives no edges
  always_ff @(posedge sys_clk) begin
    prev_r <= pins;
    for (int i = 0; i < 10; i++) begin
      if (clear) edge_cnt[i] <= 8'h00;
      else if (pins[i] && !prev_r[i]) edge_cnt[i] <= edge_cnt[i] + 8'h01;
    end
  end
endmodule // reco_pin_sink

// *** test/recovered_clock_output_select_tb.sv ***
// self-checking bench for the recovered clock selector
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("Error at %0t: got %h expected %h", \
  $time, g, e); end end
module recovered_clock_output_select_tb;
  // edges per pin in a 120-cycle window, lanes toggling every cycle
  localparam logic [7:0] FULL = 8'h3c;
  localparam logic [7:0] DIV4 = 8'h0f;
  localparam logic [7:0] DIV5 = 8'h0c;
  localparam logic [7:0] NONE = 8'h00;
  localparam logic [1:0] OK = reco_clk_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = reco_clk_pkg::RESP_SLVERR;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic clear = 1'b0;
  logic [9:0] lane_run = 10'h000, lane_lvl = 10'h000, bad = 10'h000;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [9:0] pins;
  logic [9:0][7:0] cnt;
  int miscompares = 0;
  int num_checks = 0;

  recovered_clock_output_select dut (
    .sys_clk(sys_clk), .nrst(nrst), .gig_lane_clk(lane_lvl[7:0]),
    .fast_lane_clk(lane_lvl[9:8]), .lane_timing_bad(bad),
    .recovered_clock_out_pin(pins), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready)
  );
  reco_pin_sink sink (
    .sys_clk(sys_clk), .clear(clear), .pins(pins), .edge_cnt(cnt)
  );
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  // stopped lanes sit low, as a receiver that lost lock
  always @(posedge sys_clk) lane_lvl <= ~lane_lvl & lane_run;
  //////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e = OK);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge sys_clk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(posedge sys_clk);
    bready <= 1'b1;
    do @(posedge sys_clk); while (!bvalid);
    bready <= 1'b0;
    `CHK(bresp, e)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e = OK);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    @(posedge sys_clk);
    rready <= 1'b1;
    do @(posedge sys_clk); while (!rvalid);
    rready <= 1'b0;
    `CHK(rdata, d)
    `CHK(rresp, e)
  endtask
  // window is a multiple of every output period, so phase cannot matter
  task automatic measure(input logic [79:0] e);
    repeat (20) @(posedge sys_clk);
    clear <= 1'b1;
    @(posedge sys_clk);
    clear <= 1'b0;
    // counts of the last 120 edges stand before this edge's update lands
    repeat (121) @(posedge sys_clk);
    for (int i = 0; i < 10; i++) `CHK(cnt[i], e[8*i +: 8])
  endtask
  task automatic t_reset();
    `CHK(pins, 10'h000)
    for (int a = 0; a <= 32; a += 4) rd(8'(a), 32'h0);
    rd(8'h40, 32'h0, ERR);
    wr(8'h44, 32'h1, ERR);
    $display("reset test done");
  endtask
  task automatic t_route();
    lane_run <= 10'h155;
    wr(reco_clk_pkg::OFS_ENABLE, 32'h3ff);
    measure({{4{NONE, FULL}}, NONE, FULL});
    lane_run <= 10'h3ff;
    wr(reco_clk_pkg::OFS_ENABLE, 32'h0ff);
    measure({NONE, NONE, {8{FULL}}});
    `CHK(pins[9:8], 2'h0)
    wr(reco_clk_pkg::OFS_ENABLE, 32'h3ff);
    $display("routing test done");
  endtask
  task automatic t_div();
    wr(reco_clk_pkg::OFS_GIG_DIV, 32'he4e4);
    wr(reco_clk_pkg::OFS_FAST_DIV, 32'h9);
    measure({DIV5, DIV4, {2{FULL, DIV5, DIV4, FULL}}});
    wr(reco_clk_pkg::OFS_GIG_DIV, 32'h0);
    wr(reco_clk_pkg::OFS_FAST_DIV, 32'h0);
    measure({10{FULL}});
    $display("divider test done");
  endtask
  task automatic t_common();
    lane_run <= 10'h008;
    wr(reco_clk_pkg::OFS_SELECT, 32'h3ff);
    // lane 7 also asks for the bus but is stopped: lowest lane must win
    wr(reco_clk_pkg::OFS_GIG_CLK_SEL, 32'h88);
    wr(reco_clk_pkg::OFS_COMMON_DIV, 32'h1);
    measure({10{DIV4}});
    lane_run <= 10'h200;
    wr(reco_clk_pkg::OFS_GIG_CLK_SEL, 32'h0);
    wr(reco_clk_pkg::OFS_FAST_CLK_SEL, 32'h2);
    wr(reco_clk_pkg::OFS_COMMON_DIV, 32'h2);
    measure({10{DIV5}});
    wr(reco_clk_pkg::OFS_SELECT, 32'h0);
    wr(reco_clk_pkg::OFS_FAST_CLK_SEL, 32'h0);
    wr(reco_clk_pkg::OFS_COMMON_DIV, 32'h0);
    $display("common bus test done");
  endtask
  task automatic t_pin0();
    lane_run <= 10'h020;
    wr(reco_clk_pkg::OFS_SELECT, 32'h0005_0000);
    measure({{4{NONE}}, FULL, {4{NONE}}, FULL});
    wr(reco_clk_pkg::OFS_SELECT, 32'h0);
    $display("pin zero test done");
  endtask
  task automatic t_squelch();
    lane_run <= 10'h3ff;
    wr(reco_clk_pkg::OFS_SQUELCH, 32'h1);
    measure({{9{FULL}}, NONE});
    rd(reco_clk_pkg::OFS_STATUS, 32'h3fe);
    wr(reco_clk_pkg::OFS_SQUELCH, 32'h0002_0000);
    bad <= 10'h002;
    measure({{8{FULL}}, NONE, FULL});
    bad <= 10'h000;
    repeat (4) @(posedge sys_clk);
    rd(reco_clk_pkg::OFS_STATUS, 32'h0002_03ff);
    wr(reco_clk_pkg::OFS_STATUS, 32'h0002_0000);
    rd(reco_clk_pkg::OFS_STATUS, 32'h3ff);
    wr(reco_clk_pkg::OFS_SQUELCH, 32'h0);
    $display("squelch test done");
  endtask
  task automatic test_done();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset();
    t_route();
    t_div();
    t_common();
    t_pin0();
    t_squelch();
    test_done();
  end
  // whole run is about 1400 cycles; seven times that means a hang
  initial begin
    repeat (10000) @(posedge sys_clk);
    miscompares++;
    test_done();
  end
endmodule // recovered_clock_output_select_tb
